// ==== hdl/spm_pkg.sv ====
// package for the sleep and doze power mode controller
package spm_pkg;
	localparam int ADDR_W = 4;
	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] WDOG_OFS = 4'h8;
	// control register fields
	localparam int IDLE_SEL_BIT = 0;
	localparam int DOZE_ACT_BIT = 1;
	localparam int FULL_IRQ_BIT = 2;
	localparam int DOZE_RET_BIT = 3;
	localparam int WDOG_SLP_BIT = 4;
	localparam int DOZE_RATIO_LSB = 8;
	localparam int DOZE_RATIO_W = 3;
	// status register fields
	localparam int PD_N_BIT = 0;
	localparam int TO_N_BIT = 1;
	localparam int SLEEP_BIT = 2;
	localparam int IN_IRQ_BIT = 3;
	localparam int DOZING_BIT = 4;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic PD_N_RST = 1'b1;
	localparam logic TO_N_RST = 1'b1;
	localparam int WDOG_W = 16;
	localparam logic [WDOG_W-1:0] WDOG_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP} spm_mode_t;

	typedef struct packed {
		logic sleepInstr; // sleep instruction executed
		logic irqEntry; // core vectors into handler
		logic irqReturn; // core returns from handler
		logic wakeEvent; // wake source while sleeping
	} spm_core_ev_t;
endpackage

// ==== hdl/spm_power_ctrl.sv ====
// sleep and doze power mode controller with AXI4-Lite registers
`timescale 1ns/1ps
module spm_power_ctrl (
	input wire logic sys_clk, // 100 MHz system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire spm_pkg::spm_core_ev_t coreEv, // core sequencing events, sys_clk domain
	input wire logic wdogTick, // watchdog prescaler tick, same domain
	input wire logic wdogRunInSleep, // watchdog enabled during Sleep
	input wire logic [7:0] pinOut, // core-driven pin levels
	input wire logic [7:0] pinOutEn_n, // core-driven pin enables, low drives
	output logic [7:0] padOut, // pad levels, held in Sleep
	output logic [7:0] padOutEn_n, // pad enables, low drives
	output logic coreClkEn, // core clock gate enable
	output logic coreDoze, // core runs at reduced rate
	output logic oscKeepOn, // oscillators and converter clock stay on
	output logic [spm_pkg::WDOG_W-1:0] wdogCount, // watchdog count
	input wire logic [3:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [3:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	// ==========================================================
	// bus write channel
	logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
	logic [3:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic wrFire;

	assign s_axi_awready = !awHeld_r && !bvalid_r;
	assign s_axi_wready = !wHeld_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_comb begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		wrFire = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (awHeld_r && wHeld_r) begin
			wrFire = 1'b1;
			awHeld_nxt = 1'b0;
			wHeld_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (awAddr_r == spm_pkg::CTRL_OFS) ? spm_pkg::RESP_OKAY
				: spm_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			bvalid_r <= 1'b0;
			awAddr_r <= 4'h0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			bresp_r <= spm_pkg::RESP_OKAY;
		end else begin
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			bvalid_r <= bvalid_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// ==========================================================
	// power mode state
	spm_pkg::spm_mode_t mode_r, mode_nxt;
	logic idleSel_r, idleSel_nxt, dozeAct_r, dozeAct_nxt;
	logic fullIrq_r, fullIrq_nxt, dozeRet_r, dozeRet_nxt;
	logic wdogSlp_r, wdogSlp_nxt, inIrq_r, inIrq_nxt;
	logic [spm_pkg::DOZE_RATIO_W-1:0] dozeRatio_r, dozeRatio_nxt;
	logic pdN_r, pdN_nxt, toN_r, toN_nxt;
	logic [spm_pkg::WDOG_W-1:0] wdog_r, wdog_nxt;
	logic [7:0] padOut_r, padOut_nxt, padEn_r, padEn_nxt;
	logic sleepEnter, handlerDoze_r, handlerDoze_nxt;
	logic ctrlWr;

	assign ctrlWr = wrFire && awAddr_r == spm_pkg::CTRL_OFS;
	assign sleepEnter = mode_r == spm_pkg::MODE_RUN && coreEv.sleepInstr && !idleSel_r;

	always_comb begin
		mode_nxt = mode_r;
		idleSel_nxt = idleSel_r;
		dozeAct_nxt = dozeAct_r;
		fullIrq_nxt = fullIrq_r;
		dozeRet_nxt = dozeRet_r;
		wdogSlp_nxt = wdogSlp_r;
		dozeRatio_nxt = dozeRatio_r;
		inIrq_nxt = inIrq_r;
		handlerDoze_nxt = handlerDoze_r;
		pdN_nxt = pdN_r;
		toN_nxt = toN_r;
		wdog_nxt = wdog_r;
		// software write first so hardware events below take priority
		if (ctrlWr) begin
			if (wStrb_r[0]) begin
				idleSel_nxt = wData_r[spm_pkg::IDLE_SEL_BIT];
				dozeAct_nxt = wData_r[spm_pkg::DOZE_ACT_BIT];
				fullIrq_nxt = wData_r[spm_pkg::FULL_IRQ_BIT];
				dozeRet_nxt = wData_r[spm_pkg::DOZE_RET_BIT];
				wdogSlp_nxt = wData_r[spm_pkg::WDOG_SLP_BIT];
			end
			if (wStrb_r[1]) begin
				dozeRatio_nxt = wData_r[spm_pkg::DOZE_RATIO_LSB +: spm_pkg::DOZE_RATIO_W];
			end
		end
		// watchdog counts while running, or in Sleep only when allowed
		if (wdogTick && (mode_r == spm_pkg::MODE_RUN || wdogSlp_r || wdogRunInSleep)) begin
			wdog_nxt = wdog_r + 1'b1;
		end
		if (sleepEnter) begin
			mode_nxt = spm_pkg::MODE_SLEEP;
			wdog_nxt = spm_pkg::WDOG_RST;
			pdN_nxt = 1'b0;
			toN_nxt = 1'b1;
		end else if (mode_r == spm_pkg::MODE_SLEEP && coreEv.wakeEvent) begin
			mode_nxt = spm_pkg::MODE_RUN;
		end
		// handler mode decided by the two control bits
		if (coreEv.irqEntry && !inIrq_r) begin
			inIrq_nxt = 1'b1;
			dozeRet_nxt = dozeAct_r;
			handlerDoze_nxt = dozeAct_r && !fullIrq_r;
			dozeAct_nxt = dozeAct_r && !fullIrq_r;
		end else if (coreEv.irqReturn && inIrq_r) begin
			inIrq_nxt = 1'b0;
			handlerDoze_nxt = 1'b0;
			dozeAct_nxt = dozeRet_r;
		end
	end

	// pads follow the core while awake and freeze on the Sleep edge
	always_comb begin
		padOut_nxt = padOut_r;
		padEn_nxt = padEn_r;
		if (mode_r == spm_pkg::MODE_RUN && !sleepEnter) begin
			padOut_nxt = pinOut;
			padEn_nxt = pinOutEn_n;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_r <= spm_pkg::MODE_RUN;
			idleSel_r <= spm_pkg::CTRL_RST[spm_pkg::IDLE_SEL_BIT];
			dozeAct_r <= spm_pkg::CTRL_RST[spm_pkg::DOZE_ACT_BIT];
			fullIrq_r <= spm_pkg::CTRL_RST[spm_pkg::FULL_IRQ_BIT];
			dozeRet_r <= spm_pkg::CTRL_RST[spm_pkg::DOZE_RET_BIT];
			wdogSlp_r <= spm_pkg::CTRL_RST[spm_pkg::WDOG_SLP_BIT];
			dozeRatio_r <= spm_pkg::CTRL_RST[spm_pkg::DOZE_RATIO_LSB +: spm_pkg::DOZE_RATIO_W];
			inIrq_r <= 1'b0;
			handlerDoze_r <= 1'b0;
			pdN_r <= spm_pkg::PD_N_RST;
			toN_r <= spm_pkg::TO_N_RST;
			wdog_r <= spm_pkg::WDOG_RST;
			padOut_r <= 8'h00;
			padEn_r <= 8'hFF;
		end else begin
			mode_r <= mode_nxt;
			idleSel_r <= idleSel_nxt;
			dozeAct_r <= dozeAct_nxt;
			fullIrq_r <= fullIrq_nxt;
			dozeRet_r <= dozeRet_nxt;
			wdogSlp_r <= wdogSlp_nxt;
			dozeRatio_r <= dozeRatio_nxt;
			inIrq_r <= inIrq_nxt;
			handlerDoze_r <= handlerDoze_nxt;
			pdN_r <= pdN_nxt;
			toN_r <= toN_nxt;
			wdog_r <= wdog_nxt;
			padOut_r <= padOut_nxt;
			padEn_r <= padEn_nxt;
		end
	end

	assign coreClkEn = mode_r == spm_pkg::MODE_RUN;
	assign coreDoze = inIrq_r ? handlerDoze_r : dozeAct_r;
	// sleep never requests an oscillator stop; oscKeepOn stays high even while rst_n is low
	assign oscKeepOn = 1'b1;
	// rst_n is the only reset seen here; other resets live outside and stay live
	assign wdogCount = wdog_r;
	assign padOut = padOut_r;
	assign padOutEn_n = padEn_r;

	// ==========================================================
	// bus read channel
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = spm_pkg::RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			unique case (s_axi_araddr)
				spm_pkg::CTRL_OFS: begin
					rdata_nxt[spm_pkg::IDLE_SEL_BIT] = idleSel_r;
					rdata_nxt[spm_pkg::DOZE_ACT_BIT] = dozeAct_r;
					rdata_nxt[spm_pkg::FULL_IRQ_BIT] = fullIrq_r;
					rdata_nxt[spm_pkg::DOZE_RET_BIT] = dozeRet_r;
					rdata_nxt[spm_pkg::WDOG_SLP_BIT] = wdogSlp_r;
					rdata_nxt[spm_pkg::DOZE_RATIO_LSB +: spm_pkg::DOZE_RATIO_W] = dozeRatio_r;
				end
				spm_pkg::STAT_OFS: begin
					rdata_nxt[spm_pkg::PD_N_BIT] = pdN_r;
					rdata_nxt[spm_pkg::TO_N_BIT] = toN_r;
					rdata_nxt[spm_pkg::SLEEP_BIT] = mode_r == spm_pkg::MODE_SLEEP;
					rdata_nxt[spm_pkg::IN_IRQ_BIT] = inIrq_r;
					rdata_nxt[spm_pkg::DOZING_BIT] = coreDoze;
				end
				spm_pkg::WDOG_OFS: rdata_nxt[spm_pkg::WDOG_W-1:0] = wdog_r;
				default: rresp_nxt = spm_pkg::RESP_SLVERR;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= spm_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end
endmodule // spm_power_ctrl

// ==== bench/spm_power_ctrl_monitor.sv ====
// checker for clock gating, watchdog clearing and pad hold
`timescale 1ns/1ps
module spm_power_ctrl_monitor (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire spm_pkg::spm_core_ev_t coreEv, // core events
	input wire logic wdogTick, // watchdog tick
	input wire logic [7:0] padOut, // pad levels
	input wire logic [7:0] padOutEn_n, // pad enables
	input wire logic coreClkEn, // core clock gate
	input wire logic oscKeepOn, // oscillators on
	input wire logic [spm_pkg::WDOG_W-1:0] wdogCount // watchdog count
);
	// ==========================================
	// sleep entry and exit
	a_clk_stop_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(coreClkEn) |-> $past(coreEv.sleepInstr)) else $error("clock stop without sleep");
	a_wdog_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(coreClkEn) |-> wdogCount == '0) else $error("watchdog not cleared");
	a_wdog_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(rst_n) && $changed(wdogCount) |-> $past(wdogTick) || $past(coreEv.sleepInstr))
		else $error("watchdog moved without cause");
	a_pads_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!coreClkEn && !$past(coreClkEn) |-> $stable(padOut) && $stable(padOutEn_n))
		else $error("pads moved in sleep");
	a_osc_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		oscKeepOn) else $error("oscillators dropped");
	a_wake_restores: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!coreClkEn && coreEv.wakeEvent |=> coreClkEn) else $error("no wake");
	a_sleep_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!coreClkEn && !coreEv.wakeEvent |=> !coreClkEn) else $error("left sleep alone");
	// a reset must reach the core even while it sleeps
	a_reset_runs: assert property (@(posedge sys_clk)
		!rst_n |=> coreClkEn && wdogCount == '0) else $error("reset ignored");
	c_sleep: cover property (@(posedge sys_clk) $fell(coreClkEn));
	c_wake: cover property (@(posedge sys_clk) $rose(coreClkEn));
	c_irq: cover property (@(posedge sys_clk) coreEv.irqEntry);
endmodule // spm_power_ctrl_monitor
bind spm_power_ctrl spm_power_ctrl_monitor u_mon (.sys_clk, .rst_n, .coreEv, .wdogTick,
	.padOut, .padOutEn_n, .coreClkEn, .oscKeepOn, .wdogCount);

// ==== bench/spm_core_model.sv ====
// core sequencing model issuing one-cycle event pulses
`timescale 1ns/1ps
module spm_core_model (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic go, // issue one event
	input wire logic [1:0] sel, // 0 sleep, 1 irq, 2 return, 3 wake
	output spm_pkg::spm_core_ev_t coreEv // event pulses
);
	logic inIsr_r;
	logic inIsr_nxt;
	spm_pkg::spm_core_ev_t ev_nxt;
	// no nesting and no stray return: a real core never issues them
	always_comb begin
		ev_nxt = '0;
		inIsr_nxt = inIsr_r;
		if (go) begin
			ev_nxt.sleepInstr = sel == 2'd0;
			ev_nxt.irqEntry = sel == 2'd1 && !inIsr_r;
			ev_nxt.irqReturn = sel == 2'd2 && inIsr_r;
			ev_nxt.wakeEvent = sel == 2'd3;
			inIsr_nxt = (inIsr_r || sel == 2'd1) && sel != 2'd2;
		end
	end
	always_ff @(posedge sys_clk) begin
		inIsr_r <= rst_n && inIsr_nxt;
		coreEv <= rst_n ? ev_nxt : '0;
	end
endmodule // spm_core_model

// ==== bench/spm_power_ctrl_tb.sv ====
// testbench for the sleep and doze power mode controller
`timescale 1ns/1ps
module spm_power_ctrl_tb;
	logic sys_clk, rst_n, go, tick, wrs, awv, wv, bre, arv, rre, dz, full_rate_on_irq, ovr;
	logic clkEn, doze, osc, awr, wr_, bv, arr, rv;
	logic [1:0] sel, bresp, rresp, r;
	logic [3:0] awa, ara;
	logic [31:0] wd, rdata, d;
	logic [7:0] pin, pinEn_n, pad, padEn_n;
	logic [spm_pkg::WDOG_W-1:0] wdc;
	spm_pkg::spm_core_ev_t ev;
	int error_cnt, total_checks;
	spm_core_model u_core (.sys_clk, .rst_n, .go, .sel, .coreEv(ev));
	spm_power_ctrl u_dut (.sys_clk, .rst_n, .coreEv(ev), .wdogTick(tick), .wdogRunInSleep(wrs),
		.pinOut(pin), .pinOutEn_n(pinEn_n), .padOut(pad), .padOutEn_n(padEn_n),
		.coreClkEn(clkEn), .coreDoze(doze), .oscKeepOn(osc), .wdogCount(wdc),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rre));
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// ==========================================
	// bus and event tasks
	task wr(input logic [3:0] a, input logic [31:0] v);
		logic ad, wdn;
		@(posedge sys_clk);
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		ad = 0;
		wdn = 0;
		while (!(ad && wdn)) begin
			@(posedge sys_clk);
			if (!ad && awr) begin
				ad = 1;
				awv <= 0;
			end
			if (!wdn && wr_) begin
				wdn = 1;
				wv <= 0;
			end
		end
		do @(posedge sys_clk); while (!bv);
		r = bresp;
		bre <= 0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		ara <= a;
		arv <= 1;
		rre <= 1;
		do @(posedge sys_clk); while (!arr);
		arv <= 0;
		do @(posedge sys_clk); while (!rv);
		d = rdata;
		r = rresp;
		rre <= 0;
	endtask
	task evt(input logic [1:0] s);
		@(posedge sys_clk);
		sel <= s;
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task ticks(input int n);
		@(posedge sys_clk);
		tick <= 1;
		repeat (n) @(posedge sys_clk);
		tick <= 0;
		@(posedge sys_clk);
		#1;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
	// ==========================================
	// tests
	initial begin
		{rst_n, go, sel, tick, wrs, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		pin = 8'h00;
		pinEn_n = 8'hFF;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1;
		rd(spm_pkg::CTRL_OFS);
		chk("ctrl", spm_pkg::CTRL_RST, d);
		rd(spm_pkg::STAT_OFS);
		chk("pd", spm_pkg::PD_N_RST, d[spm_pkg::PD_N_BIT]);
		rd(4'hC);
		chk("unmapped", spm_pkg::RESP_SLVERR, r);
		wr(spm_pkg::STAT_OFS, 32'hFFFF_FFFF);
		chk("ro write", spm_pkg::RESP_SLVERR, r);
		$display("test regs done");
		wr(spm_pkg::CTRL_OFS, 32'h0000_0001);
		evt(0);
		chk("idle clk", 1, clkEn);
		@(posedge sys_clk);
		pin <= 8'hA5;
		pinEn_n <= 8'h0F;
		wr(spm_pkg::CTRL_OFS, 32'h0000_0000);
		ticks(3);
		chk("wdog run", 3, wdc);
		evt(0);
		chk("sleep clk", 0, clkEn);
		chk("wdog clr", 0, wdc);
		chk("osc", 1, osc);
		@(posedge sys_clk);
		pin <= 8'h5A;
		pinEn_n <= 8'hF0;
		rd(spm_pkg::STAT_OFS);
		chk("pad", 8'hA5, pad);
		chk("pad en", 8'h0F, padEn_n);
		chk("pd n", 0, d[spm_pkg::PD_N_BIT]);
		chk("to n", 1, d[spm_pkg::TO_N_BIT]);
		// neither enable set: ticks in Sleep must be ignored
		ticks(1);
		chk("wdog stop", 0, wdc);
		wr(spm_pkg::CTRL_OFS, 32'h0000_0010);
		ticks(2);
		chk("wdog slp", 2, wdc);
		wr(spm_pkg::CTRL_OFS, 32'h0000_0000);
		wrs <= 1;
		ticks(1);
		chk("wdog pin", 3, wdc);
		evt(3);
		chk("wake clk", 1, clkEn);
		chk("pad wake", 8'h5A, pad);
		evt(0);
		@(posedge sys_clk);
		rst_n <= 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1;
		#1;
		chk("rst clk", 1, clkEn);
		$display("test sleep done");
		// the fifth pass rewrites the return bit inside the handler
		for (int k = 0; k < 5; k++) begin
			{ovr, full_rate_on_irq, dz} = 3'(k);
			wr(spm_pkg::CTRL_OFS, {29'h0, full_rate_on_irq, dz, 1'b0});
			evt(1);
			chk("isr doze", dz & !full_rate_on_irq, doze);
			rd(spm_pkg::CTRL_OFS);
			chk("ret bit", dz, d[spm_pkg::DOZE_RET_BIT]);
			chk("isr act", dz & !full_rate_on_irq, d[spm_pkg::DOZE_ACT_BIT]);
			if (ovr)
				wr(spm_pkg::CTRL_OFS, {28'h0, !dz, full_rate_on_irq, dz & !full_rate_on_irq, 1'b0});
			evt(2);
			chk("ret doze", dz ^ ovr, doze);
			rd(spm_pkg::CTRL_OFS);
			chk("ret act", dz ^ ovr, d[spm_pkg::DOZE_ACT_BIT]);
		end
		$display("test doze done");
		tally_and_finish;
	end
endmodule // spm_power_ctrl_tb
